//--- hdl/prma_pkg.sv
// Purpose: constants for the probe register map block
// Assumes: 200 MHz sys_clk, 16-bit registers, decimal register numbers
// Notes: geometry fixes every table placement below
package prma_pkg;
  // clock
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
  // address-space geometry
  localparam logic [7:0] MAX_SENS = 8'h20;
  localparam logic [7:0] NUM_TYPES = 8'h03;
  localparam int unsigned TABLE_LEN = 32 * 3;
  localparam int unsigned MASK_WORDS = (TABLE_LEN + 15) / 16;
  // register numbers
  localparam logic [15:0] REG_PROGRESS = 16'h7532;
  localparam logic [15:0] REG_DET_BASE = 16'h7539;
  localparam logic [15:0] REG_PROC_BASE = 16'h753f;
  localparam logic [15:0] REG_GEOMETRY = 16'h7594;
  localparam logic [15:0] REG_DEPTH_BASE = 16'h7595;
  localparam logic [15:0] REG_COOKED_BASE = 16'h7631;
  localparam logic [15:0] REG_BAUD = 16'h9c41;
  localparam logic [15:0] REG_CMD = 16'h9c42;
  localparam logic [15:0] CMD_MEASURE = 16'h0001;
  // progress codes
  localparam logic [15:0] PROG_IDLE = 16'h0000;
  localparam logic [15:0] PROG_RUNNING = 16'h0001;
  localparam logic [15:0] PROG_DONE = 16'h0002;
  localparam logic [15:0] PROG_FAILED = 16'h0003;
  localparam logic [31:0] FLOAT_NAN = 32'h7fc00000;
  // baud selection
  localparam logic [2:0] BAUD_1200 = 3'h0;
  localparam logic [2:0] BAUD_2400 = 3'h1;
  localparam logic [2:0] BAUD_9600 = 3'h2;
  localparam logic [2:0] BAUD_19200 = 3'h3;
  localparam logic [2:0] BAUD_38400 = 3'h4;
  localparam logic [2:0] BAUD_RESET = BAUD_9600;
  localparam logic [17:0] DIV_1200 = 18'(CLK_HZ / 1200);
  localparam logic [17:0] DIV_2400 = 18'(CLK_HZ / 2400);
  localparam logic [17:0] DIV_9600 = 18'(CLK_HZ / 9600);
  localparam logic [17:0] DIV_19200 = 18'(CLK_HZ / 19200);
  localparam logic [17:0] DIV_38400 = 18'(CLK_HZ / 38400);
  // sampling limit per sensor
  localparam int unsigned SAMPLE_MAX_MS = 50;
  localparam int unsigned SAMPLE_MAX_CYC = SAMPLE_MAX_MS * CLK_KHZ;
  // states
  typedef enum logic [2:0] {
    PX_IDLE = 3'b000,
    PX_RD_HI = 3'b001,
    PX_RD_LO = 3'b010,
    PX_WR_HI = 3'b011,
    PX_WR_LO = 3'b100
  } prma_port_e;
  typedef enum logic [1:0] {
    SM_IDLE = 2'b00,
    SM_SCAN = 2'b01,
    SM_WAIT = 2'b10
  } prma_samp_e;
endpackage : prma_pkg

//--- hdl/probe_register_map_access.sv
// Purpose: register map, byte order, baud tick and sampling sequencer
// Assumes: link framing and sensor front end sit outside, on sys_clk
// Notes: registers travel as two bytes, high byte first
// Contract
// - multi-word values put low word first
// - each register byte order is high byte first
// - geometry reports 32 sensors, 3 types
// - bitmask uses two registers per type
// - tables span all allocated types times sensors
// - geometry places registers, not hardware support
// - depth table exposed for every sensor
// - baud 1200 to 38400, default 9600
// - single sensor sampling ends within 50 ms
// - progress reads 1 running, 2 done, 3 failed
`timescale 1ns/1ps
module probe_register_map_access #(
  parameter int unsigned SAMPLE_LIMIT = prma_pkg::SAMPLE_MAX_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  output logic req_ready,
  output logic resp_err,
  // write data bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  // read data bytes
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  // link rate
  output logic [2:0] baud_code,
  output logic bit_tick,
  // sensor front end
  input wire logic [prma_pkg::TABLE_LEN-1:0] sensor_present,
  output logic sample_req,
  output logic [6:0] sample_idx,
  input wire logic sample_done,
  input wire logic sample_fail,
  input wire logic [31:0] sample_value
);
  import prma_pkg::*;

  localparam logic [6:0] LAST = 7'(TABLE_LEN);
  localparam logic [23:0] LIMIT_M1 = 24'(SAMPLE_LIMIT - 1);

  // presence pins come from another domain
  logic [TABLE_LEN-1:0] pres_meta_q, pres_q;
  always_ff @(posedge sys_clk) begin
    pres_meta_q <= rst_n ? sensor_present : '0;
    pres_q <= rst_n ? pres_meta_q : '0;
  end

  // port state
  prma_port_e px_q, px_d;
  logic [15:0] word_q, word_d, wr_addr_q, wr_addr_d;
  logic [7:0] wr_hi_q, wr_hi_d;
  logic err_q, err_d;
  logic [2:0] baud_q, baud_d;
  logic [15:0] depth_q [TABLE_LEN];
  logic [15:0] depth_d [TABLE_LEN];
  logic start_cmd;

  // sampler state
  prma_samp_e sm_q, sm_d;
  logic [6:0] idx_q, idx_d;
  logic [23:0] tmr_q, tmr_d;
  logic [15:0] prog_q, prog_d;
  logic fail_q, fail_d;
  logic [TABLE_LEN-1:0] proc_q, proc_d;
  logic [31:0] cooked_q [TABLE_LEN];
  logic [31:0] cooked_d [TABLE_LEN];

  // read decode
  logic [15:0] rdata, off;
  logic rhit;
  always_comb begin
    rdata = 16'h0000;
    rhit = 1'b0;
    off = 16'h0000;
    if (req_addr == REG_GEOMETRY) begin
      rhit = 1'b1;
      rdata = {NUM_TYPES, MAX_SENS};
    end else if (req_addr == REG_PROGRESS) begin
      rhit = 1'b1;
      rdata = prog_q;
    end else if (req_addr == REG_BAUD) begin
      rhit = 1'b1;
      rdata = {13'h0000, baud_q};
    end else if (req_addr == REG_CMD) begin
      rhit = 1'b1;
    end else if (req_addr - REG_DET_BASE < 16'(MASK_WORDS)) begin
      off = req_addr - REG_DET_BASE;
      rhit = 1'b1;
      rdata = pres_q[off[2:0]*16 +: 16];
    end else if (req_addr - REG_PROC_BASE < 16'(MASK_WORDS)) begin
      off = req_addr - REG_PROC_BASE;
      rhit = 1'b1;
      rdata = proc_q[off[2:0]*16 +: 16];
    end else if (req_addr - REG_DEPTH_BASE < 16'(TABLE_LEN)) begin
      off = req_addr - REG_DEPTH_BASE;
      rhit = 1'b1;
      rdata = depth_q[off[6:0]];
    end else if (req_addr - REG_COOKED_BASE < 16'(2 * TABLE_LEN)) begin
      off = req_addr - REG_COOKED_BASE;
      rhit = 1'b1;
      // low word sits at the lower register
      rdata = off[0] ? cooked_q[off[7:1]][31:16]
                     : cooked_q[off[7:1]][15:0];
    end
  end

  // request and byte handling
  logic [15:0] wdata, woff;
  always_comb begin
    px_d = px_q;
    word_d = word_q;
    wr_addr_d = wr_addr_q;
    wr_hi_d = wr_hi_q;
    baud_d = baud_q;
    depth_d = depth_q;
    err_d = 1'b0;
    start_cmd = 1'b0;
    wdata = {wr_hi_q, rx_byte};
    woff = wr_addr_q - REG_DEPTH_BASE;
    req_ready = (px_q == PX_IDLE);
    rx_ready = (px_q == PX_WR_HI) || (px_q == PX_WR_LO);
    tx_valid = (px_q == PX_RD_HI) || (px_q == PX_RD_LO);
    case (px_q)
      PX_IDLE: begin
        if (req_valid && req_write) begin
          wr_addr_d = req_addr;
          px_d = PX_WR_HI;
        end else if (req_valid) begin
          // unmapped reads answer with an error and no bytes
          word_d = rdata;
          err_d = !rhit;
          px_d = rhit ? PX_RD_HI : PX_IDLE;
        end
      end
      PX_RD_HI: begin
        if (tx_ready) begin
          px_d = PX_RD_LO;
        end
      end
      PX_RD_LO: begin
        if (tx_ready) begin
          px_d = PX_IDLE;
        end
      end
      PX_WR_HI: begin
        if (rx_valid) begin
          wr_hi_d = rx_byte;
          px_d = PX_WR_LO;
        end
      end
      PX_WR_LO: begin
        if (rx_valid) begin
          px_d = PX_IDLE;
          if (wr_addr_q == REG_BAUD) begin
            // unknown rate codes leave the link rate alone
            if (wdata <= {13'h0000, BAUD_38400}) begin
              baud_d = wdata[2:0];
            end else begin
              err_d = 1'b1;
            end
          end else if (wr_addr_q == REG_CMD) begin
            start_cmd = (wdata == CMD_MEASURE);
            err_d = (wdata != CMD_MEASURE);
          end else if (woff < 16'(TABLE_LEN)) begin
            depth_d[woff[6:0]] = wdata;
          end else begin
            err_d = 1'b1;
          end
        end
      end
      default: begin
        px_d = PX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      px_q <= PX_IDLE;
      word_q <= 16'h0000;
      wr_addr_q <= 16'h0000;
      wr_hi_q <= 8'h00;
      err_q <= 1'b0;
      baud_q <= BAUD_RESET;
      for (int i = 0; i < TABLE_LEN; i++) begin
        depth_q[i] <= 16'h0000;
      end
    end else begin
      px_q <= px_d;
      word_q <= word_d;
      wr_addr_q <= wr_addr_d;
      wr_hi_q <= wr_hi_d;
      err_q <= err_d;
      baud_q <= baud_d;
      depth_q <= depth_d;
    end
  end

  assign resp_err = err_q;
  assign tx_byte = (px_q == PX_RD_HI) ? word_q[15:8] : word_q[7:0];
  assign baud_code = baud_q;

  // bit-rate enable
  logic [17:0] cnt_q, cnt_d, div;
  logic [2:0] bsel_q;
  always_comb begin
    case (baud_q)
      BAUD_1200: div = DIV_1200;
      BAUD_2400: div = DIV_2400;
      BAUD_19200: div = DIV_19200;
      BAUD_38400: div = DIV_38400;
      default: div = DIV_9600;
    endcase
    // a rate change restarts the period rather than running long
    if (bsel_q != baud_q || cnt_q >= div - 18'h00001) begin
      cnt_d = 18'h00000;
    end else begin
      cnt_d = cnt_q + 18'h00001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= 18'h00000;
      bsel_q <= BAUD_RESET;
      bit_tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      bsel_q <= baud_q;
      bit_tick <= (bsel_q == baud_q) && (cnt_q >= div - 18'h00001);
    end
  end

  // measurement sequencer
  always_comb begin
    sm_d = sm_q;
    idx_d = idx_q;
    tmr_d = tmr_q;
    prog_d = prog_q;
    fail_d = fail_q;
    proc_d = proc_q;
    cooked_d = cooked_q;
    sample_req = 1'b0;
    case (sm_q)
      SM_IDLE: begin
        if (start_cmd) begin
          for (int i = 0; i < TABLE_LEN; i++) begin
            cooked_d[i] = 32'h00000000;
          end
          proc_d = '0;
          fail_d = 1'b0;
          idx_d = 7'h00;
          prog_d = PROG_RUNNING;
          sm_d = SM_SCAN;
        end
      end
      SM_SCAN: begin
        tmr_d = 24'h000000;
        if (idx_q == LAST) begin
          prog_d = fail_q ? PROG_FAILED : PROG_DONE;
          sm_d = SM_IDLE;
        end else if (pres_q[idx_q]) begin
          sm_d = SM_WAIT;
        end else begin
          idx_d = idx_q + 7'h01;
        end
      end
      SM_WAIT: begin
        sample_req = 1'b1;
        if (sample_done || tmr_q == LIMIT_M1) begin
          // an overrun counts as a failed sensor
          cooked_d[idx_q] = (sample_done && !sample_fail) ?
                            sample_value : FLOAT_NAN;
          fail_d = fail_q | !sample_done | sample_fail;
          proc_d[idx_q] = 1'b1;
          idx_d = idx_q + 7'h01;
          sm_d = SM_SCAN;
        end else begin
          tmr_d = tmr_q + 24'h000001;
        end
      end
      default: begin
        sm_d = SM_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sm_q <= SM_IDLE;
      idx_q <= 7'h00;
      tmr_q <= 24'h000000;
      prog_q <= PROG_IDLE;
      fail_q <= 1'b0;
      proc_q <= '0;
      for (int i = 0; i < TABLE_LEN; i++) begin
        cooked_q[i] <= 32'h00000000;
      end
    end else begin
      sm_q <= sm_d;
      idx_q <= idx_d;
      tmr_q <= tmr_d;
      prog_q <= prog_d;
      fail_q <= fail_d;
      proc_q <= proc_d;
      cooked_q <= cooked_d;
    end
  end

  assign sample_idx = idx_q;
endmodule : probe_register_map_access

//--- tb/prma_chk.sv
// Purpose: port assertions for the register map block
// Assumes: one sys_clk domain, rst_n synchronous active low
// Notes: wait bound allows the done-at-limit race
`timescale 1ns/1ps
module prma_chk import prma_pkg::*; #(
  parameter int unsigned SAMPLE_LIMIT = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic req_ready,
  input wire logic resp_err,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  // rate and sampler
  input wire logic [2:0] baud_code,
  input wire logic sample_req,
  input wire logic [6:0] sample_idx,
  input wire logic sample_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] wait_q, wait_d;
  logic rd_geo, rd_end;
  assign rd_geo = req_valid && req_ready && !req_write
    && req_addr == REG_GEOMETRY;
  assign rd_end = req_valid && req_ready && !req_write
    && req_addr == REG_DEPTH_BASE + 16'h0060;
  always_comb begin
    wait_d = sample_req ? wait_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge sys_clk) begin
    wait_q <= rst_n ? wait_d : 32'h0;
  end
  rate_legal_a: assert property (baud_code <= BAUD_38400)
    else $error("rate code out of range");
  geo_high_a: assert property (rd_geo |=> tx_valid && tx_byte == NUM_TYPES)
    else $error("geometry high byte wrong");
  geo_low_a: assert property (rd_geo ##1 tx_ready |=> tx_byte == MAX_SENS)
    else $error("geometry low byte wrong");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> $stable(tx_byte))
    else $error("read byte changed while stalled");
  table_end_a: assert property (rd_end |=> resp_err && !tx_valid)
    else $error("read past depth table answered");
  sample_limit_a: assert property (wait_q <= SAMPLE_LIMIT + 1)
    else $error("sample wait over limit");
  sample_end_a: assert property (sample_req && sample_done |=> !sample_req)
    else $error("sample request held after done");
  idx_order_a: assert property (sample_idx != $past(sample_idx) |->
    sample_idx == $past(sample_idx) + 7'h1 || sample_idx == 7'h0)
    else $error("sample index out of order");
endmodule : prma_chk

bind probe_register_map_access prma_chk #(.SAMPLE_LIMIT(SAMPLE_LIMIT)) chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
  .req_write(req_write), .req_addr(req_addr), .req_ready(req_ready),
  .resp_err(resp_err), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_ready(tx_ready), .baud_code(baud_code), .sample_req(sample_req),
  .sample_idx(sample_idx), .sample_done(sample_done)
);

//--- tb/prma_sensor_model.sv
// Purpose: sensor front end answering the sampler
// Assumes: sample_done changes on the falling edge; fail and value also follow sample_idx
// Notes: one index stays mute to force the time limit, one reports failure
`timescale 1ns/1ps
module prma_sensor_model #(
  parameter logic [6:0] MUTE_IDX = 7'h05,
  parameter logic [6:0] FAIL_IDX = 7'h07
) (
  // clock
  input wire logic sys_clk,
  // sampler handshake
  input wire logic sample_req,
  input wire logic [6:0] sample_idx,
  output logic sample_done,
  output logic sample_fail,
  output logic [31:0] sample_value
);
  logic [1:0] dly = 2'h0;
  initial sample_done = 1'b0;
  // failure flag only qualifies a finished sample
  assign sample_fail = sample_done && (sample_idx == FAIL_IDX);
  // not valid outside the done pulse, so show the inverse
  assign sample_value = {32{!sample_done}}
    ^ {9'h080, sample_idx, 9'h024, sample_idx};
  always @(negedge sys_clk) begin
    sample_done <= 1'b0;
    dly <= 2'h0;
    if (sample_req && !sample_done && sample_idx != MUTE_IDX) begin
      dly <= dly + 2'h1;
      if (dly == sample_idx[1:0]) sample_done <= 1'b1;
    end
  end
endmodule : prma_sensor_model

//--- tb/probe_register_map_access_tb.sv
// Purpose: self-checking bench for the register map block
// Assumes: short sample limit, sensor model on the sampler side
// Notes: read bytes checked by a monitor against a queue
`timescale 1ns/1ps
module probe_register_map_access_tb;
  import prma_pkg::*;
  localparam int unsigned LIM = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, rx_valid = 1'b0;
  logic tx_ready = 1'b0;
  logic [15:0] req_addr = 16'h0000, d, ts;
  logic [7:0] rx_byte = 8'h00, tx_byte;
  logic [TABLE_LEN-1:0] present = '0;
  logic req_ready, resp_err, rx_ready, tx_valid, bit_tick, sample_req;
  logic sample_done, sample_fail;
  logic [2:0] baud_code;
  logic [6:0] sample_idx;
  logic [31:0] sample_value, seed = 32'h40;
  logic [7:0] byte_q[$];
  int fail_count = 0, check_count = 0, err_exp = 0, err_seen = 0;
  int n_tick = 0;
  initial forever #2.5 sys_clk = ~sys_clk;
  probe_register_map_access #(.SAMPLE_LIMIT(LIM)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_ready(req_ready),
    .resp_err(resp_err), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .baud_code(baud_code), .bit_tick(bit_tick),
    .sensor_present(present), .sample_req(sample_req),
    .sample_idx(sample_idx), .sample_done(sample_done),
    .sample_fail(sample_fail), .sample_value(sample_value));
  prma_sensor_model sens (.sys_clk(sys_clk), .sample_req(sample_req),
    .sample_idx(sample_idx), .sample_done(sample_done),
    .sample_fail(sample_fail), .sample_value(sample_value));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // bad requests expect one error pulse and no bytes
  task automatic xfer(input logic w, input logic [15:0] a,
      input logic [15:0] v, input logic bad);
    int n;
    n = 0;
    if (bad) err_exp++;
    else if (!w) byte_q.push_back(v[15:8]);
    if (!bad && !w) byte_q.push_back(v[7:0]);
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    @(negedge sys_clk);
    req_valid = 1'b0;
    if (w) begin
      rx_valid = 1'b1;
      rx_byte = v[15:8];
      cmp(16'(rx_ready), 16'h0001);
      @(negedge sys_clk);
      rx_byte = v[7:0];
      @(negedge sys_clk);
      rx_valid = 1'b0;
    end
    while (req_ready !== 1'b1 && n < 200) begin
      tx_ready = 1'(rnd() >> 7);
      @(negedge sys_clk);
      n++;
    end
    cmp(16'(n < 200), 16'h0001);
  endtask : xfer
  always @(posedge sys_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      cmp(16'(tx_byte), byte_q.size() ? 16'(byte_q.pop_front()) : 16'h1ff);
    if (resp_err === 1'b1) err_seen++;
  end
  initial begin
    #(5 * 40000);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    cmp(16'(baud_code), 16'(BAUD_RESET));
    xfer(1'b0, REG_GEOMETRY, {NUM_TYPES, MAX_SENS}, 1'b0);
    for (int c = 0; c < 5; c++) begin
      xfer(1'b1, REG_BAUD, 16'(c), 1'b0);
      cmp(16'(baud_code), 16'(c));
    end
    xfer(1'b1, REG_BAUD, 16'h0005, 1'b1);
    xfer(1'b0, REG_BAUD, 16'h0004, 1'b0);
    xfer(1'b1, REG_GEOMETRY, 16'h0000, 1'b1);
    xfer(1'b0, REG_DEPTH_BASE + 16'h0060, 16'h0000, 1'b1);
    xfer(1'b1, REG_CMD, 16'h0002, 1'b1);
    d = 16'(rnd());
    xfer(1'b1, REG_DEPTH_BASE, d, 1'b0);
    xfer(1'b0, REG_DEPTH_BASE, d, 1'b0);
    xfer(1'b1, REG_DEPTH_BASE + 16'h005f, ~d, 1'b0);
    xfer(1'b0, REG_DEPTH_BASE + 16'h005f, ~d, 1'b0);
    ts = REG_DET_BASE + 16'h0002 * (16'h0002 - 16'h0001);
    for (int r = 0; r < 2; r++) begin
      present = {rnd(), rnd(), rnd()};
      present[5] = (r == 0);
      present[7] = (r == 0);
      present[40] = 1'b1;
      repeat (4) @(negedge sys_clk);
      xfer(1'b1, REG_CMD, CMD_MEASURE, 1'b0);
      xfer(1'b0, REG_PROGRESS, PROG_RUNNING, 1'b0);
      // worst case: every index waits out the whole limit
      repeat (TABLE_LEN * (LIM + 3)) @(negedge sys_clk);
      xfer(1'b0, REG_PROGRESS, r ? PROG_DONE : PROG_FAILED, 1'b0);
      xfer(1'b0, REG_COOKED_BASE + 16'd80, {9'h024, 7'd40}, 1'b0);
      xfer(1'b0, REG_COOKED_BASE + 16'd81, {9'h080, 7'd40}, 1'b0);
      d = r ? 16'h0000 : FLOAT_NAN[15:0];
      xfer(1'b0, REG_COOKED_BASE + 16'd10, d, 1'b0);
      xfer(1'b0, REG_COOKED_BASE + 16'd14, d, 1'b0);
      d = r ? 16'h0000 : FLOAT_NAN[31:16];
      xfer(1'b0, REG_COOKED_BASE + 16'd11, d, 1'b0);
      xfer(1'b0, REG_COOKED_BASE + 16'd15, d, 1'b0);
      xfer(1'b0, ts, present[47:32], 1'b0);
      xfer(1'b0, ts + 16'h0001, present[63:48], 1'b0);
      xfer(1'b0, REG_PROC_BASE + 16'h0002, present[47:32], 1'b0);
    end
    // bit period at the last rate written, 38400
    while (bit_tick !== 1'b1) begin
      @(negedge sys_clk);
    end
    @(negedge sys_clk);
    while (bit_tick !== 1'b1) begin
      @(negedge sys_clk);
      n_tick++;
    end
    cmp(16'(n_tick + 1), 16'(CLK_HZ / 38400));
    repeat (2) @(negedge sys_clk);
    cmp(16'(err_seen), 16'(err_exp));
    cmp(16'(byte_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule : probe_register_map_access_tb
